// ---- hdl/bpv_params.svh ----
// Constants for the banked program counter and vector unit
`ifndef BPV_PARAMS_SVH
`define BPV_PARAMS_SVH
`define BPV_PC_W        17
`define BPV_SP_W        16
`define BPV_START_LOW   17'h00000
`define BPV_START_HIGH  17'h0FE00
`define BPV_VEC_EXT0    17'h00003
`define BPV_VEC_EXT1    17'h0000B
`define BPV_VEC_GRP2    17'h00013
`define BPV_VEC_GRP3    17'h0001B
`define BPV_VEC_T0H     17'h00023
`define BPV_VEC_T1      17'h0002B
`define BPV_VEC_GRP6    17'h00033
`define BPV_VEC_GRP7    17'h0003B
`define BPV_VEC_GRP8    17'h00043
`define BPV_VEC_GRP9    17'h0004B
`define BPV_SP_RESET    16'h0000
`endif

// ---- hdl/bpv_pkg.sv ----
// Types shared by the banked program counter and vector unit
package bpv_pkg;
  // Source group being accepted (one vector per group)
  typedef enum logic [3:0] {
    BPV_SRC_EXT0 = 4'h0,
    BPV_SRC_EXT1 = 4'h1,
    BPV_SRC_GRP2 = 4'h2,
    BPV_SRC_GRP3 = 4'h3,
    BPV_SRC_T0H  = 4'h4,
    BPV_SRC_T1   = 4'h5,
    BPV_SRC_GRP6 = 4'h6,
    BPV_SRC_GRP7 = 4'h7,
    BPV_SRC_GRP8 = 4'h8,
    BPV_SRC_GRP9 = 4'h9
  } bpv_src_t;

  // Control-flow operation presented by the decoder for one executed instruction
  typedef enum logic [1:0] {
    BPV_OP_SEQ  = 2'h0,
    BPV_OP_JUMP = 2'h1,
    BPV_OP_CALL = 2'h2,
    BPV_OP_RET  = 2'h3
  } bpv_op_t;

  // One executed instruction as the decoder presents it
  typedef struct packed {
    logic      valid;
    bpv_op_t   op;
    logic [16:0] target;
    logic [2:0]  len;
  } bpv_instr_t;

  // Two stack words read for a return: upper at SP, lower at SP-1
  typedef struct packed {
    logic [8:0] upper;
    logic [8:0] lower;
  } bpv_ret_t;

  // Stack push: two 9-bit words and their addresses
  typedef struct packed {
    logic        valid;
    logic [15:0] addr_low;
    logic [8:0]  data_low;
    logic [15:0] addr_high;
    logic [8:0]  data_high;
  } bpv_push_t;

  // Sequencer state (Gray along reset -> run)
  typedef enum logic [1:0] {
    BPV_ST_RESET = 2'b00,
    BPV_ST_RUN   = 2'b01
  } bpv_state_t;
endpackage : bpv_pkg

// ---- hdl/bpv_unit.sv ----
// Banked program counter with reset, interrupt vector and stack push logic
`timescale 1ns/1ps
`include "bpv_params.svh"

module bpv_unit #(
  parameter bit FIXED_VARIANT = 1'b0
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 start_high_sel_i,
  input  wire bpv_pkg::bpv_instr_t  instr_i,
  input  wire logic                 irq_accept_i,
  input  wire bpv_pkg::bpv_src_t    irq_src_i,
  input  wire bpv_pkg::bpv_ret_t    ret_data_i,
  input  wire logic [15:0]          sp_i,
  output logic [16:0]               pc_o,
  output logic                      bank_select_flag_o,
  output logic [17:0]               fetch_addr_o,
  output bpv_pkg::bpv_push_t        push_o,
  output logic [15:0]               sp_o
);
  import bpv_pkg::*;

  logic [16:0] pc_reg;
  logic        bank_reg;
  bpv_push_t   push_reg;
  logic [15:0] sp_reg;
  bpv_state_t  state_reg;
  logic [16:0] pc_next;
  logic        bank_next;
  logic        push_next;

  // Vector table decode for the load path; the assertions use a vector constant or its literal value directly
  function automatic logic [16:0] vec_of(input bpv_src_t s);
    case (s)
      BPV_SRC_EXT0: vec_of = `BPV_VEC_EXT0;
      BPV_SRC_EXT1: vec_of = `BPV_VEC_EXT1;
      BPV_SRC_GRP2: vec_of = `BPV_VEC_GRP2;
      BPV_SRC_GRP3: vec_of = `BPV_VEC_GRP3;
      BPV_SRC_T0H:  vec_of = `BPV_VEC_T0H;
      BPV_SRC_T1:   vec_of = `BPV_VEC_T1;
      BPV_SRC_GRP6: vec_of = `BPV_VEC_GRP6;
      BPV_SRC_GRP7: vec_of = `BPV_VEC_GRP7;
      BPV_SRC_GRP8: vec_of = `BPV_VEC_GRP8;
      BPV_SRC_GRP9: vec_of = `BPV_VEC_GRP9;
      default:      vec_of = `BPV_VEC_EXT0;
    endcase
  endfunction : vec_of

  // Start address: strap caught after release, fixed variant ignores it
  function automatic logic [16:0] start_of(input logic hi);
    start_of = (hi && !FIXED_VARIANT) ? `BPV_START_HIGH : `BPV_START_LOW;
  endfunction : start_of

  // Leaves the reset state at the first edge that sees reset released;
  // the strap is read straight into the start load there, so no copy of it is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= BPV_ST_RESET;
    end else begin
      state_reg <= BPV_ST_RUN;
    end
  end

  // Next counter and flag; interrupt outranks an instruction in the same cycle
  always_comb begin
    pc_next   = pc_reg;
    bank_next = bank_reg;
    push_next = 1'b0;
    if (state_reg == BPV_ST_RESET) begin
      pc_next   = start_of(start_high_sel_i);
      bank_next = 1'b0;
    end else if (irq_accept_i) begin
      pc_next   = vec_of(irq_src_i);
      bank_next = 1'b0;
      push_next = 1'b1;
    end else if (instr_i.valid) begin
      case (instr_i.op)
        BPV_OP_SEQ: begin
          // Wraps within the 128K bank; flag untouched
          pc_next = pc_reg + 17'(instr_i.len);
        end
        BPV_OP_JUMP: begin
          pc_next = instr_i.target;
        end
        BPV_OP_CALL: begin
          pc_next   = instr_i.target;
          push_next = 1'b1;
        end
        BPV_OP_RET: begin
          pc_next   = {ret_data_i.upper, ret_data_i.lower[7:0]};
          bank_next = ret_data_i.lower[8];
        end
        default: begin
          pc_next = pc_reg;
        end
      endcase
    end
  end

  // Counter and bank flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_reg   <= `BPV_START_LOW;
      bank_reg <= 1'b0;
    end else begin
      pc_reg   <= pc_next;
      bank_reg <= bank_next;
    end
  end

  // Return address push; the old counter is the one saved
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      push_reg <= '0;
      sp_reg   <= `BPV_SP_RESET;
    end else begin
      push_reg.valid <= push_next;
      sp_reg         <= push_next ? sp_i + 16'h0002 : sp_i;
      if (push_next) begin
        push_reg.addr_low  <= sp_i + 16'h0001;
        push_reg.data_low  <= {bank_reg, pc_reg[7:0]};
        push_reg.addr_high <= sp_i + 16'h0002;
        push_reg.data_high <= pc_reg[16:8];
      end
    end
  end

  assign pc_o               = pc_reg;
  assign bank_select_flag_o = bank_reg;
  assign fetch_addr_o       = {bank_reg, pc_reg};
  assign push_o             = push_reg;
  assign sp_o               = sp_reg;

  // Sequential step keeps the bank
  seq_keeps_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && !irq_accept_i && instr_i.valid && instr_i.op == BPV_OP_SEQ)
    |=> (bank_reg == $past(bank_reg)) && (pc_reg == 17'($past(pc_reg) + $past(instr_i.len))))
    else $error("sequential step broke counter or bank");

  // Bank flag is set only by a return
  bank_only_ret_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(bank_reg) && $past(state_reg) == BPV_ST_RUN && bank_reg)
    |-> $past(instr_i.valid && instr_i.op == BPV_OP_RET && !irq_accept_i))
    else $error("bank set without a return");

  // Jumps and calls load target
  branch_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && !irq_accept_i && instr_i.valid &&
     (instr_i.op == BPV_OP_JUMP || instr_i.op == BPV_OP_CALL))
    |=> pc_reg == $past(instr_i.target))
    else $error("branch target not loaded");

  // Start address after reset; sampled rst_i skips the release edge, which still
  // saw reset and so cannot have loaded the start address yet
  reset_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && state_reg == BPV_ST_RESET && start_high_sel_i && !FIXED_VARIANT)
    |=> pc_reg == `BPV_START_HIGH && !bank_reg)
    else $error("high start address not loaded");

  // Fixed variant starts at zero
  fixed_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && state_reg == BPV_ST_RESET && (FIXED_VARIANT || !start_high_sel_i))
    |=> pc_reg == `BPV_START_LOW && !bank_reg)
    else $error("start address not zero");

  // Interrupt vector and flag clear
  irq_vector_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && irq_accept_i && irq_src_i == BPV_SRC_EXT1)
    |=> pc_reg == `BPV_VEC_EXT1 && !bank_reg && push_o.valid &&
        push_o.addr_low == 16'($past(sp_i) + 16'h0001))
    else $error("interrupt vector wrong");

  // Timer-1 shared vector
  shared_vector_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && irq_accept_i && irq_src_i == BPV_SRC_T1)
    |=> pc_reg == 17'h0002B)
    else $error("shared vector wrong");

  // Push layout
  push_layout_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && irq_accept_i)
    |=> push_o.valid && push_o.data_high == $past(pc_reg[16:8]) &&
        push_o.data_low == {$past(bank_reg), $past(pc_reg[7:0])} &&
        sp_o == 16'($past(sp_i) + 16'h0002))
    else $error("push layout wrong");

  // Return reload
  ret_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && !irq_accept_i && instr_i.valid && instr_i.op == BPV_OP_RET)
    |=> pc_reg == {$past(ret_data_i.upper), $past(ret_data_i.lower[7:0])} &&
        bank_reg == $past(ret_data_i.lower[8]))
    else $error("return reload wrong");

  // Reset cycle ignores an interrupt
  reset_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RESET && irq_accept_i) |=> !push_o.valid)
    else $error("interrupt taken during reset load");

  // No push without a call or an interrupt, and the pointer just follows
  push_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && !irq_accept_i && !(instr_i.valid && instr_i.op == BPV_OP_CALL))
    |=> !push_o.valid && sp_o == $past(sp_i))
    else $error("push without call or interrupt");

  // Anything but a return or an interrupt leaves the bank flag alone
  bank_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == BPV_ST_RUN && !irq_accept_i && !(instr_i.valid && instr_i.op == BPV_OP_RET))
    |=> bank_reg == $past(bank_reg))
    else $error("bank flag changed without a return");
endmodule : bpv_unit

// ---- verif/bpv_stack_model.sv ----
// Stack memory model on the far side: takes pushes, serves return words
`timescale 1ns/1ps
module bpv_stack_model (
  input  wire logic               clk_i,
  input  wire bpv_pkg::bpv_push_t push_i,
  input  wire logic [15:0]        sp_i,
  input  wire logic               wr_en_i,
  input  wire logic [7:0]         wr_addr_i,
  input  wire logic [8:0]         wr_data_i,
  output bpv_pkg::bpv_ret_t       ret_o
);
  import bpv_pkg::*;
  logic [8:0] mem [256];
  // Only 256 words are kept; the bench stays inside that window
  always_ff @(posedge clk_i) begin
    if (push_i.valid) begin
      mem[push_i.addr_low[7:0]]  <= push_i.data_low;
      mem[push_i.addr_high[7:0]] <= push_i.data_high;
    end
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
  // Upper word at SP, lower word at SP-1
  assign ret_o = '{upper: mem[sp_i[7:0]], lower: mem[sp_i[7:0] - 8'h01]};
endmodule : bpv_stack_model

// ---- verif/tb.sv ----
// Self-checking bench for the banked program counter and vector unit
`timescale 1ns/1ps
module tb;
  import bpv_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start_high_sel_i = 1'b0;
  bpv_instr_t  instr_i = '0;
  logic        irq_accept_i = 1'b0;
  bpv_src_t    irq_src_i = BPV_SRC_EXT0;
  bpv_ret_t    ret_data_i;
  logic [15:0] sp_i = 16'h0040;
  logic [16:0] pc_o;
  logic        bank_select_flag_o;
  logic [17:0] fetch_addr_o;
  bpv_push_t   push_o;
  logic [15:0] sp_o;
  logic        wr_en = 1'b0;
  logic [7:0]  wr_addr = 8'h00;
  logic [8:0]  wr_data = 9'h000;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [16:0] vec [10] = '{17'h00003, 17'h0000B, 17'h00013, 17'h0001B, 17'h00023,
                            17'h0002B, 17'h00033, 17'h0003B, 17'h00043, 17'h0004B};

  always #4 clk_i = ~clk_i;

  bpv_unit bpv_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .start_high_sel_i(start_high_sel_i),
    .instr_i(instr_i), .irq_accept_i(irq_accept_i), .irq_src_i(irq_src_i),
    .ret_data_i(ret_data_i), .sp_i(sp_i), .pc_o(pc_o), .bank_select_flag_o(bank_select_flag_o),
    .fetch_addr_o(fetch_addr_o), .push_o(push_o), .sp_o(sp_o));
  bpv_stack_model bpv_stack_model_inst (.clk_i(clk_i), .push_i(push_o), .sp_i(sp_i),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .ret_o(ret_data_i));

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // Hang guard: all tests need well under 200 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end

  // Reset with an interrupt and a jump pending, so the start load must win
  task automatic do_reset(input logic high);
    @(posedge clk_i);
    rst_i <= 1'b1;
    start_high_sel_i <= high;
    irq_accept_i <= 1'b1;
    instr_i <= '{1'b1, BPV_OP_JUMP, 17'h05555, 3'h1};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    irq_accept_i <= 1'b0;
    instr_i <= '0;
    #1;
  endtask : do_reset

  task automatic step(input bpv_op_t op, input logic [16:0] tgt, input logic [2:0] len);
    @(posedge clk_i);
    instr_i <= '{1'b1, op, tgt, len};
    @(posedge clk_i);
    instr_i <= '0;
    #1;
  endtask : step

  // Interrupt with a competing jump in the same cycle; the jump must be dropped
  task automatic irq(input bpv_src_t src);
    @(posedge clk_i);
    irq_accept_i <= 1'b1;
    irq_src_i <= src;
    instr_i <= '{1'b1, BPV_OP_JUMP, 17'h0AAAA, 3'h2};
    @(posedge clk_i);
    irq_accept_i <= 1'b0;
    instr_i <= '0;
    #1;
  endtask : irq

  task automatic t_reset;
    do_reset(1'b1);
    chk(fetch_addr_o, {1'b0, 17'h0FE00});
    chk({bank_select_flag_o, pc_o}, {1'b0, 17'h0FE00});
    chk(push_o.valid, 18'h00000);
    do_reset(1'b0);
    chk(fetch_addr_o, 18'h00000);
    step(BPV_OP_JUMP, 17'h1FFFE, 3'h0);
    chk(fetch_addr_o, {1'b0, 17'h1FFFE});
    step(BPV_OP_SEQ, 17'h00000, 3'h3);
    chk(fetch_addr_o, 18'h00001);
    $display("reset and sequence test done");
  endtask : t_reset

  task automatic t_ret;
    @(posedge clk_i);
    wr_en <= 1'b1;
    wr_addr <= 8'h40;
    wr_data <= 9'h012;
    @(posedge clk_i);
    wr_addr <= 8'h3F;
    wr_data <= 9'h134;
    @(posedge clk_i);
    wr_en <= 1'b0;
    step(BPV_OP_RET, 17'h00000, 3'h0);
    chk(fetch_addr_o, {1'b1, 17'h01234});
    chk(sp_o, 18'h00040);
    step(BPV_OP_SEQ, 17'h00000, 3'h3);
    chk(fetch_addr_o, {1'b1, 17'h01237});
    step(BPV_OP_CALL, 17'h1F000, 3'h0);
    chk(fetch_addr_o, {1'b1, 17'h1F000});
    chk(push_o.valid, 18'h00001);
    chk({push_o.data_low, push_o.data_high}, {9'h137, 9'h012});
    chk({push_o.addr_low[8:0], push_o.addr_high[8:0]}, {9'h041, 9'h042});
    chk(sp_o, 18'h00042);
    @(posedge clk_i);
    sp_i <= 16'h0042;
    step(BPV_OP_RET, 17'h00000, 3'h0);
    chk(fetch_addr_o, {1'b1, 17'h01237});
    step(BPV_OP_JUMP, 17'h00100, 3'h0);
    chk(fetch_addr_o, {1'b1, 17'h00100});
    $display("return and call test done");
  endtask : t_ret

  task automatic t_irq;
    logic [17:0] prev;
    prev = {1'b1, 17'h00100};
    @(posedge clk_i);
    sp_i <= 16'h0010;
    for (int i = 0; i < 10; i++) begin
      irq(bpv_src_t'(i));
      chk(fetch_addr_o, {1'b0, vec[i]});
      chk({push_o.data_low, push_o.data_high}, {prev[17], prev[7:0], prev[16:8]});
      chk({push_o.addr_low[8:0], push_o.addr_high[8:0]}, {9'h011, 9'h012});
      chk(sp_o, 18'h00012);
      prev = {1'b0, vec[i]};
    end
    @(posedge clk_i);
    #1;
    chk(push_o.valid, 18'h00000);
    $display("interrupt vector test done");
  endtask : t_irq

  initial begin
    t_reset();
    t_ret();
    t_irq();
    print_verdict();
  end
endmodule : tb
